// ### rtl/fixed_reference_pkg.sv
// Purpose: Shared constants and types for the fixed reference control block
// Assumes: 8-bit control register reached over classic Wishbone, 32-bit data
// Notes:   Word offsets are byte addresses; narrow data sits in the low bits
package fixed_reference_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [3:0] REF_CONTROL_OFS = 4'h0;
  localparam logic [3:0] REF_STATUS_OFS  = 4'h4;

  // Control register field positions
  localparam int unsigned ENABLE_BIT   = 7;
  localparam int unsigned READY_BIT    = 6;
  localparam int unsigned TEMP_SENSE_ENABLE_BIT     = 5;
  localparam int unsigned TRANGE_BIT   = 4;
  localparam int unsigned GAIN_LSB     = 0;

  // Reset values of the writable fields
  localparam logic [1:0] GAIN_RESET    = 2'h0;
  localparam logic       BIT_RESET     = 1'b0;

  // Stabilisation time, in ns, and its cycle count at 25 MHz
  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned SETTLE_TIME_NS  = 25000;
  localparam int unsigned SETTLE_CYCLES   =
    (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Brown-out mode field encodings
  localparam logic [1:0] BOR_SW_CTRL    = 2'h1;
  localparam logic [1:0] BOR_SLEEP_OFF  = 2'h2;
  localparam logic [1:0] BOR_ALWAYS     = 2'h3;

  typedef enum logic [1:0] {
    GAIN_OFF = 2'b00,
    GAIN_1X  = 2'b01,
    GAIN_2X  = 2'b10,
    GAIN_4X  = 2'b11
  } gain_e;

  typedef enum logic [1:0] {
    REF_OFF    = 2'b00,
    REF_SETTLE = 2'b01,
    REF_READY  = 2'b10
  } ref_state_e;

  // Peripheral demands on the reference
  typedef struct packed {
    logic       oscillator_config_bit;
    logic [1:0] brownout_mode_field;
    logic       brownout_fast_start;
    logic       regulator_sleep_mode_bit;
    logic       sleeping;
  } periph_req_s;

  // Analog-side controls
  typedef struct packed {
    logic ref_power;
    logic amp_on;
    logic gain_1x;
    logic gain_2x;
    logic gain_4x;
    logic temp_sense_enable;
    logic temp_range_select;
  } analog_ctl_s;

endpackage

// ### rtl/fixed_reference_control.sv
// Purpose: Control register and ready sequencing for the fixed voltage reference
// Assumes: One clock, synchronous active-high reset, classic Wishbone slave
// Notes:   Ready flag comes from a settle counter, reset to not-ready
//
// Implementation choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RL1: Enable bit 7 powers reference and amplifier
// RL2: Ready bit 6 set after stabilisation time
// RL3: Ready read-only, reset value follows condition; the code resets ready to 0 and sets it only after the settle count
// RL4: Gain field enables amplifier and sets gain
// RL5: Codes 11/10/01 give 4x/2x/1x gain
// RL6: Converter copy has exactly three gain choices
// RL7: Brown-out 10 with fast start holds reference
// RL8: Brown-out 01 with fast start holds reference
// RL9: Regulator sleep bit awake holds reference
// RL10: External clock or brown-out 11 holds reference
// RL11: Bit 5 enables temperature indicator
// RL12: Bit 4 selects temperature range high/low
// RL13: Gain 00 off; bits 3:2 read zero
module fixed_reference_control #(
  parameter int unsigned SETTLE_CNT = fixed_reference_pkg::SETTLE_CYCLES
) (
  input  wire logic                             clk_i,
  input  wire logic                             rst_i,
  input  wire logic                             cyc_i,
  input  wire logic                             stb_i,
  input  wire logic                             we_i,
  input  wire logic [3:0]                       sel_i,
  input  wire logic [fixed_reference_pkg::ADDR_W-1:0] adr_i,
  input  wire logic [fixed_reference_pkg::DATA_W-1:0] dat_i,
  output logic      [fixed_reference_pkg::DATA_W-1:0] dat_o,
  output logic                                  ack_o,
  output logic                                  err_o,
  input  wire fixed_reference_pkg::periph_req_s periph_i,
  output fixed_reference_pkg::analog_ctl_s      analog_o
);

  logic       enable_r;
  logic       temp_sense_enable_r;
  logic       trange_r;
  logic [1:0] gain_r;
  logic       ack_r;
  logic       err_r;
  logic [31:0] dat_r;
  logic [15:0] cnt_r;
  fixed_reference_pkg::ref_state_e state_r;
  fixed_reference_pkg::ref_state_e state_nxt;
  fixed_reference_pkg::analog_ctl_s analog_r;

  function automatic logic [2:0] gain_decode(input logic [1:0] code);
    case (code)
      fixed_reference_pkg::GAIN_4X: gain_decode = 3'h4;
      fixed_reference_pkg::GAIN_2X: gain_decode = 3'h2;
      fixed_reference_pkg::GAIN_1X: gain_decode = 3'h1;
      default:                      gain_decode = 3'h0;
    endcase
  endfunction

  // Bus decode
  wire req      = cyc_i && stb_i && !ack_r && !err_r;
  wire hit_ctl  = adr_i == fixed_reference_pkg::REF_CONTROL_OFS;
  wire hit_stat = adr_i == fixed_reference_pkg::REF_STATUS_OFS;
  wire hit      = hit_ctl || hit_stat;
  wire wr_ctl   = req && we_i && hit_ctl && sel_i[0];

  // Peripheral requests keeping the reference alive
  wire [1:0] bor  = periph_i.brownout_mode_field;
  wire req_bor10  = (bor == fixed_reference_pkg::BOR_SLEEP_OFF)
                    && periph_i.brownout_fast_start; // RL7
  wire req_bor01  = (bor == fixed_reference_pkg::BOR_SW_CTRL)
                    && periph_i.brownout_fast_start; // RL8
  wire req_vreg   = periph_i.regulator_sleep_mode_bit && !periph_i.sleeping; // RL9
  wire req_osc    = periph_i.oscillator_config_bit
                    || (bor == fixed_reference_pkg::BOR_ALWAYS); // RL10
  wire periph_req = req_bor10 || req_bor01 || req_vreg || req_osc;
  wire ref_on     = enable_r || periph_req; // RL1

  wire [2:0] gain_sel = gain_decode(gain_r); // RL5
  wire       ready    = (state_r == fixed_reference_pkg::REF_READY);

  wire [7:0] ctl_view = {enable_r, ready, temp_sense_enable_r, trange_r, 2'h0, gain_r}; // RL13
  wire [31:0] rd_val  = hit_ctl ? {24'h0, ctl_view}
                                : {31'h0, ref_on};

  // Ready sequencing: counter restarts whenever the reference drops
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      fixed_reference_pkg::REF_OFF:
        if (ref_on) state_nxt = fixed_reference_pkg::REF_SETTLE;
      fixed_reference_pkg::REF_SETTLE:
        if (!ref_on) state_nxt = fixed_reference_pkg::REF_OFF;
        else if (cnt_r == 16'(SETTLE_CNT - 1)) state_nxt = fixed_reference_pkg::REF_READY; // RL2
      fixed_reference_pkg::REF_READY:
        if (!ref_on) state_nxt = fixed_reference_pkg::REF_OFF;
      default: state_nxt = fixed_reference_pkg::REF_OFF;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= fixed_reference_pkg::REF_OFF; // RL3
      cnt_r   <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= (state_r == fixed_reference_pkg::REF_SETTLE) ? cnt_r + 16'h0001 : 16'h0000;
    end
  end

  // Control register; ready bit is never written
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_r <= fixed_reference_pkg::BIT_RESET;
      temp_sense_enable_r   <= fixed_reference_pkg::BIT_RESET;
      trange_r <= fixed_reference_pkg::BIT_RESET;
      gain_r   <= fixed_reference_pkg::GAIN_RESET;
    end else if (wr_ctl) begin
      enable_r <= dat_i[fixed_reference_pkg::ENABLE_BIT]; // RL1
      temp_sense_enable_r   <= dat_i[fixed_reference_pkg::TEMP_SENSE_ENABLE_BIT]; // RL11
      trange_r <= dat_i[fixed_reference_pkg::TRANGE_BIT]; // RL12
      gain_r   <= dat_i[fixed_reference_pkg::GAIN_LSB +: 2]; // RL4
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req && hit;
      err_r <= req && !hit;
      dat_r <= (req && hit && !we_i) ? rd_val : 32'h0000_0000;
    end
  end

  // Analog controls registered so the pins never glitch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      analog_r <= '0;
    end else begin
      analog_r.ref_power         <= ref_on; // RL1
      analog_r.amp_on            <= ref_on && (gain_r != fixed_reference_pkg::GAIN_OFF); // RL13
      analog_r.gain_1x           <= ref_on && gain_sel[0]; // RL6
      analog_r.gain_2x           <= ref_on && gain_sel[1];
      analog_r.gain_4x           <= ref_on && gain_sel[2];
      analog_r.temp_sense_enable <= temp_sense_enable_r; // RL11
      analog_r.temp_range_select <= trange_r; // RL12
    end
  end

  assign ack_o    = ack_r;
  assign err_o    = err_r;
  assign dat_o    = dat_r;
  assign analog_o = analog_r;

  property p_ready_after_settle;
    @(posedge clk_i) disable iff (rst_i)
      (ref_on && state_r == fixed_reference_pkg::REF_OFF) ##1 ref_on [*3]
        |-> !ready;
  endproperty
  a_ready_after_settle: assert property (p_ready_after_settle) // RL2
    else $error("ready rose too early");

  property p_ready_needs_on;
    @(posedge clk_i) disable iff (rst_i) ready |-> $past(ref_on);
  endproperty
  a_ready_needs_on: assert property (p_ready_needs_on) // RL2
    else $error("ready without reference on");

  property p_enable_powers;
    @(posedge clk_i) disable iff (rst_i) enable_r |=> analog_o.ref_power;
  endproperty
  a_enable_powers: assert property (p_enable_powers) // RL1
    else $error("enable did not power reference");

  property p_ready_ro;
    @(posedge clk_i) disable iff (rst_i)
      (wr_ctl && dat_i[fixed_reference_pkg::READY_BIT] && !ref_on && !periph_req) |=> !ready;
  endproperty
  a_ready_ro: assert property (p_ready_ro) // RL3
    else $error("ready written by software");

  property p_gain_4x;
    @(posedge clk_i) disable iff (rst_i)
      (ref_on && gain_r == fixed_reference_pkg::GAIN_4X) |=> analog_o.gain_4x && !analog_o.gain_1x;
  endproperty
  a_gain_4x: assert property (p_gain_4x) // RL5
    else $error("gain 11 not 4x");

  property p_one_gain;
    @(posedge clk_i) disable iff (rst_i)
      $onehot0({analog_o.gain_1x, analog_o.gain_2x, analog_o.gain_4x});
  endproperty
  a_one_gain: assert property (p_one_gain) // RL6
    else $error("more than one gain active");

  property p_bor10;
    @(posedge clk_i) disable iff (rst_i) req_bor10 |=> analog_o.ref_power;
  endproperty
  a_bor10: assert property (p_bor10) // RL7
    else $error("brown-out 10 did not hold reference");

  property p_bor01;
    @(posedge clk_i) disable iff (rst_i) req_bor01 |=> analog_o.ref_power;
  endproperty
  a_bor01: assert property (p_bor01) // RL8
    else $error("brown-out 01 did not hold reference");

  property p_vreg;
    @(posedge clk_i) disable iff (rst_i) req_vreg |=> analog_o.ref_power;
  endproperty
  a_vreg: assert property (p_vreg) // RL9
    else $error("regulator request ignored");

  property p_gain_off;
    @(posedge clk_i) disable iff (rst_i)
      (gain_r == fixed_reference_pkg::GAIN_OFF) |=> !analog_o.amp_on;
  endproperty
  a_gain_off: assert property (p_gain_off) // RL13
    else $error("amplifier on with gain 00");

  c_ready: cover property (@(posedge clk_i) disable iff (rst_i) $rose(ready));
  c_periph: cover property (@(posedge clk_i) disable iff (rst_i) !enable_r && periph_req);
  c_write: cover property (@(posedge clk_i) disable iff (rst_i) wr_ctl);
  c_err: cover property (@(posedge clk_i) disable iff (rst_i) err_o);

endmodule

`default_nettype wire

// ### test/ref_analog_model.sv
// Purpose: Behavioural model of the analog reference and converter gain stage
// Assumes: Control levels from the block are registered and glitch free
// Notes:   Reports the gain in use and flags an illegal mix of gain lines
`timescale 1ns/1ps
`default_nettype none
module ref_analog_model (
  input  wire fixed_reference_pkg::analog_ctl_s ana_i,
  output logic [2:0]                            gain_o,
  output logic                                  bad_o
);
  // One-hot gain lines read directly as the multiplier 1, 2 or 4
  assign gain_o = {ana_i.gain_4x, ana_i.gain_2x, ana_i.gain_1x};
  // Amplifier without reference power, or two gains at once, cannot exist
  assign bad_o = (ana_i.amp_on & ~ana_i.ref_power)
               | (ana_i.amp_on != (|gain_o))
               | ((gain_o & (gain_o - 3'h1)) != 3'h0);
endmodule
`default_nettype wire

// ### test/fixed_reference_control_tb_top.sv
// Purpose: Self-checking bench for the fixed reference control block
// Assumes: Short settle count so the ready flag rises within a few cycles
// Notes:   Register traffic is classic Wishbone, single cycles only
`timescale 1ns/1ps
`default_nettype none
module fixed_reference_control_tb_top;
  localparam int unsigned SETTLE = 4;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [3:0]  sel   = 4'h0;
  logic [3:0]  adr   = 4'h0;
  logic [31:0] wdat  = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        err;
  logic [2:0]  gain;
  logic        bad;
  logic [31:0] q;
  logic        e;
  int          fail_count = 0;
  int          tests_run  = 0;
  fixed_reference_pkg::periph_req_s per = '0;
  fixed_reference_pkg::analog_ctl_s ana;

  always #20 clk_i = ~clk_i;

  fixed_reference_control #(.SETTLE_CNT(SETTLE)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .sel_i(sel), .adr_i(adr), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .err_o(err), .periph_i(per), .analog_o(ana));

  ref_analog_model model (.ana_i(ana), .gain_o(gain), .bad_o(bad));

  task automatic report_and_stop;
    if (fail_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
    q = rdat;
    e = err;
    chk("bus answer", 32'h1, {31'h0, n < 20});
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic t_reset;
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    chk("control after reset", 32'h0, q);
    chk("analog after reset", 32'h0, {25'h0, ana});
  endtask

  task automatic t_enable;
    bus(1'b1, 4'h0, 32'h80, 4'h0);
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    chk("write without byte select", 32'h0, q);
    // Ready bit written as one must not stick
    bus(1'b1, 4'h0, 32'hC0, 4'h1);
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    chk("ready before settle", 32'h80, q);
    chk("reference powered", 32'h1, {31'h0, ana.ref_power});
    repeat (SETTLE + 2) @(posedge clk_i);
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    chk("ready after settle", 32'hC0, q);
  endtask

  task automatic t_gain;
    logic [2:0] xg [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
    // Temperature bits follow the gain code so all four pairs are seen
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, 4'h0, {24'h0, 2'b10, c[1:0], 2'b11, c[1:0]}, 4'h1);
      bus(1'b0, 4'h0, 32'h0, 4'hF);
      chk("control readback", {24'h0, 2'b11, c[1:0], 2'b00, c[1:0]}, q);
      chk("gain line", {29'h0, xg[c]}, {29'h0, gain});
      chk("amplifier on", {31'h0, c != 0}, {31'h0, ana.amp_on});
      chk("gain stage legal", 32'h0, {31'h0, bad});
      chk("temp controls", c, {30'h0, ana.temp_sense_enable, ana.temp_range_select});
    end
  endtask

  task automatic t_disable;
    bus(1'b1, 4'h0, 32'h3, 4'h1);
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    chk("control after disable", 32'h3, q);
    chk("reference off", 32'h0, {31'h0, ana.ref_power});
    chk("gain off unpowered", 32'h0, {29'h0, gain});
  endtask

  task automatic t_periph;
    logic [5:0] pv [10] = '{6'h20, 6'h18, 6'h14, 6'h10, 6'h0C,
                            6'h08, 6'h02, 6'h03, 6'h04, 6'h00};
    logic       rq [10] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1,
                            1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    for (int i = 0; i < 10; i++) begin
      per <= pv[i];
      repeat (2) @(posedge clk_i);
      bus(1'b0, 4'h4, 32'h0, 4'hF);
      chk("status powered", {31'h0, rq[i]}, q);
      chk("reference held", {31'h0, rq[i]}, {31'h0, ana.ref_power});
    end
  endtask

  task automatic t_unmapped;
    bus(1'b1, 4'h8, 32'hFF, 4'hF);
    chk("unmapped error", 32'h1, {31'h0, e});
    bus(1'b1, 4'h4, 32'hFF, 4'hF);
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    chk("control untouched", 32'h3, q);
  endtask

  // Reset in mid-run with a peripheral still holding the reference on
  task automatic t_reset_mid;
    per   <= 6'h20;
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    chk("control after mid reset", 32'h0, q);
    chk("reference held after reset", 32'h1, {31'h0, ana.ref_power});
    repeat (SETTLE + 2) @(posedge clk_i);
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    chk("ready from condition", 32'h40, q);
    per <= 6'h00;
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_enable();
    t_gain();
    t_disable();
    t_periph();
    t_unmapped();
    t_reset_mid();
    report_and_stop();
  end

  initial begin
    repeat (3000) @(posedge clk_i);
    fail_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
